// *** design/flash_poll_host.sv ***
`timescale 1ns/1ps
// Behaviour
// - host reads status at a programmed address or erasing sector.
// - host reads twice, compares toggle bit; unchanged means done.
// - still toggling and limit flag high: recheck, then reset on fail.
// - after interruption host restarts polling from the double read.
// - host samples window flag before and after each added erase; here the flag is only shown in status bit 4 for software to read.
// - each added sector load within 50us of previous strobe; the host has no timer or sector load logic for this.
module flash_poll_host
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // axi4-lite write
  input wire logic [7:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  // axi4-lite read
  input wire logic [7:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  // flash pins
  output logic [19:0] f_addr,
  output logic f_ce_n,
  output logic f_oe_n,
  output logic f_we_n,
  output logic [7:0] f_dq_o,
  output logic f_dq_oe,
  input wire logic [7:0] f_dq_i,
  input wire logic ready_busy_out
);
  typedef enum logic [2:0] {P_IDLE, P_RD1, P_RD2, P_RECHK, P_RST,
    P_END} poll_t;
  logic rst_s1;
  logic rst_n;
  logic rb_s1;
  logic rb_s2;
  poll_t st;
  logic [19:0] addr;
  logic [7:0] expect_data;
  logic erase_mode;
  logic esp_mode;
  logic busy;
  logic done;
  logic fail;
  logic [7:0] first;
  logic [7:0] last;
  logic cy_req;
  logic cy_wr;
  logic cy_done;
  logic [7:0] cy_rdata;
  logic aw_got;
  logic w_got;
  logic [7:0] aw_addr;
  logic [31:0] w_data;

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rst_s1 <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_s1 <= 1'b1;
      rst_n <= rst_s1;
    end
  end

  // ready/busy pin sync; low means device busy
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rb_s1 <= 1'b1;
      rb_s2 <= 1'b1;
    end
    else
    begin
      rb_s1 <= ready_busy_out;
      rb_s2 <= rb_s1;
    end
  end

  flash_bus_cycle u_cycle
  (
    .clk(ref_clk),
    .rst_n(rst_n),
    .req(cy_req),
    .is_write(cy_wr),
    .addr(addr),
    .wdata(flash_poll_pkg::RESET_CMD),
    .done(cy_done),
    .rdata(cy_rdata),
    .f_addr(f_addr),
    .f_ce_n(f_ce_n),
    .f_oe_n(f_oe_n),
    .f_we_n(f_we_n),
    .f_dq_o(f_dq_o),
    .f_dq_oe(f_dq_oe),
    .f_dq_i(f_dq_i)
  );

  // register write decode
  wire wr_fire = aw_got && w_got && !s_bvalid;
  wire ctrl_wr = wr_fire && (aw_addr == flash_poll_pkg::CTRL_OFF);
  wire addr_wr = wr_fire && (aw_addr == flash_poll_pkg::ADDR_OFF);
  wire data_wr = wr_fire && (aw_addr == flash_poll_pkg::DATA_OFF);
  wire wr_known = ctrl_wr || addr_wr || data_wr;
  wire aw_take = s_awvalid && s_awready;
  wire w_take = s_wvalid && s_wready;
  wire next_aw_got = wr_fire ? 1'b0 : (aw_got || aw_take);
  wire next_w_got = wr_fire ? 1'b0 : (w_got || w_take);
  wire next_bvalid = wr_fire ? 1'b1 : (s_bvalid && !s_bready);
  wire start_cmd = ctrl_wr && s_wstrb[0]
    && w_data[flash_poll_pkg::CTRL_START_BIT];
  wire reset_cmd = ctrl_wr && s_wstrb[0]
    && w_data[flash_poll_pkg::CTRL_RESET_BIT];

  // polling decisions
  wire toggled = (first[flash_poll_pkg::BTOG_BIT]
    != cy_rdata[flash_poll_pkg::BTOG_BIT]);
  wire limit_hit = cy_rdata[flash_poll_pkg::TLIM_BIT];
  wire cyc_idle = (st == P_IDLE) || (st == P_END);

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h00000000;
      s_bvalid <= 1'b0;
      s_bresp <= 2'h0;
      s_awready <= 1'b0;
      s_wready <= 1'b0;
    end
    else
    begin
      // registered readies, reopened once the response is taken
      s_awready <= !next_aw_got && !next_bvalid;
      s_wready <= !next_w_got && !next_bvalid;
      if (aw_take)
      begin
        aw_got <= 1'b1;
        aw_addr <= {s_awaddr[7:2], 2'h0};
      end
      if (w_take)
      begin
        w_got <= 1'b1;
        w_data <= s_wdata;
      end
      if (wr_fire)
      begin
        aw_got <= 1'b0;
        w_got <= 1'b0;
        s_bvalid <= 1'b1;
        s_bresp <= wr_known ? 2'h0 : 2'h2;
      end
      else if (s_bvalid && s_bready)
        s_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      addr <= flash_poll_pkg::ANY_ADDR;
      expect_data <= 8'h00;
      erase_mode <= 1'b0;
      esp_mode <= 1'b0;
    end
    else
    begin
      if (addr_wr && cyc_idle)
        addr <= w_data[19:0];
      if (data_wr && cyc_idle)
        expect_data <= w_data[7:0];
      if (ctrl_wr && cyc_idle)
      begin
        erase_mode <= w_data[flash_poll_pkg::CTRL_ERASE_BIT];
        esp_mode <= w_data[flash_poll_pkg::CTRL_ESP_BIT];
      end
    end
  end

  // polling state machine; every start begins with a fresh double read
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st <= P_IDLE;
      cy_req <= 1'b0;
      cy_wr <= 1'b0;
      first <= 8'h00;
      last <= 8'h00;
      busy <= 1'b0;
      done <= 1'b0;
      fail <= 1'b0;
    end
    else
    begin
      cy_req <= 1'b0;
      case (st)
        P_IDLE, P_END:
        begin
          if (start_cmd)
          begin
            st <= P_RD1;
            cy_req <= 1'b1;
            cy_wr <= 1'b0;
            busy <= 1'b1;
            done <= 1'b0;
            fail <= 1'b0;
          end
          else if (reset_cmd)
          begin
            st <= P_RST;
            cy_req <= 1'b1;
            cy_wr <= 1'b1;
            busy <= 1'b1;
          end
        end
        P_RD1:
        begin
          if (cy_done)
          begin
            first <= cy_rdata;
            last <= cy_rdata;
            cy_req <= 1'b1;
            st <= P_RD2;
          end
        end
        P_RD2, P_RECHK:
        begin
          if (cy_done)
          begin
            last <= cy_rdata;
            first <= cy_rdata;
            if (!toggled)
            begin
              st <= P_END;
              busy <= 1'b0;
              done <= 1'b1;
            end
            else if (st == P_RECHK)
            begin
              st <= P_RST;
              cy_req <= 1'b1;
              cy_wr <= 1'b1;
              fail <= 1'b1;
            end
            else
            begin
              cy_req <= 1'b1;
              st <= limit_hit ? P_RECHK : P_RD2;
            end
          end
        end
        P_RST:
        begin
          if (cy_done)
          begin
            st <= P_END;
            busy <= 1'b0;
            cy_wr <= 1'b0;
          end
        end
        default: st <= P_IDLE;
      endcase
    end
  end

  // read side
  wire [7:0] ar_word = {s_araddr[7:2], 2'h0};
  // window flag exposed so software can check it around each added erase
  wire [31:0] st_word = {26'h0000000,
    last[flash_poll_pkg::ESTG_BIT], last[flash_poll_pkg::EWIN_BIT],
    rb_s2, fail, done, busy};
  wire [31:0] ctrl_word = {28'h0000000, esp_mode, erase_mode, 2'h0};
  wire ar_known = (ar_word == flash_poll_pkg::CTRL_OFF)
    || (ar_word == flash_poll_pkg::STATUS_OFF)
    || (ar_word == flash_poll_pkg::ADDR_OFF)
    || (ar_word == flash_poll_pkg::DATA_OFF)
    || (ar_word == flash_poll_pkg::LAST_OFF);
  wire [31:0] rd_mux =
    (ar_word == flash_poll_pkg::CTRL_OFF) ? ctrl_word :
    (ar_word == flash_poll_pkg::STATUS_OFF) ? st_word :
    (ar_word == flash_poll_pkg::ADDR_OFF) ? {12'h000, addr} :
    (ar_word == flash_poll_pkg::DATA_OFF) ? {24'h000000, expect_data} :
    (ar_word == flash_poll_pkg::LAST_OFF) ? {24'h000000, last} :
    32'h00000000;

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_arready <= 1'b0;
      s_rvalid <= 1'b0;
      s_rdata <= 32'h00000000;
      s_rresp <= 2'h0;
    end
    else
    begin
      s_arready <= 1'b0;
      if (s_arvalid && !s_arready && !s_rvalid)
      begin
        s_arready <= 1'b1;
        s_rvalid <= 1'b1;
        s_rdata <= rd_mux;
        s_rresp <= ar_known ? 2'h0 : 2'h2;
      end
      else if (s_rvalid && s_rready)
        s_rvalid <= 1'b0;
    end
  end

  property p_second_read;
    @(posedge ref_clk) disable iff (!rst_n)
    (st == P_RD1 && cy_done) |=> (st == P_RD2 && cy_req);
  endproperty
  a_second_read: assert property (p_second_read)
    else $error("second status read not issued");

  property p_done_on_still;
    @(posedge ref_clk) disable iff (!rst_n)
    ((st == P_RD2 || st == P_RECHK) && cy_done && !toggled)
      |=> (done && !busy && st == P_END);
  endproperty
  a_done_on_still: assert property (p_done_on_still)
    else $error("stable toggle bit did not end polling");

  property p_fail_reset;
    @(posedge ref_clk) disable iff (!rst_n)
    (st == P_RECHK && cy_done && toggled)
      |=> (fail && st == P_RST && cy_req && cy_wr);
  endproperty
  a_fail_reset: assert property (p_fail_reset)
    else $error("failed operation not followed by reset command");

  property p_recheck;
    @(posedge ref_clk) disable iff (!rst_n)
    (st == P_RD2 && cy_done && toggled && limit_hit) |=> (st == P_RECHK);
  endproperty
  a_recheck: assert property (p_recheck)
    else $error("limit flag did not trigger recheck");

  property p_restart;
    @(posedge ref_clk) disable iff (!rst_n)
    (cyc_idle && start_cmd) |=> (st == P_RD1 && busy && !fail);
  endproperty
  a_restart: assert property (p_restart)
    else $error("polling did not restart with a double read");

  property p_keep_polling;
    @(posedge ref_clk) disable iff (!rst_n)
    (st == P_RD2 && cy_done && toggled && !limit_hit)
      |=> (st == P_RD2 && cy_req && !cy_wr);
  endproperty
  a_keep_polling: assert property (p_keep_polling)
    else $error("toggling without limit did not keep polling");

  property p_reset_ends;
    @(posedge ref_clk) disable iff (!rst_n)
    (st == P_RST && cy_done) |=> (!busy && st == P_END);
  endproperty
  a_reset_ends: assert property (p_reset_ends)
    else $error("reset command did not end busy");

  property p_addr_stable;
    @(posedge ref_clk) disable iff (!rst_n)
    (!cyc_idle) |=> $stable(addr);
  endproperty
  a_addr_stable: assert property (p_addr_stable)
    else $error("status address changed while polling");

  c_done: cover property (@(posedge ref_clk) disable iff (!rst_n)
    st == P_RD2 ##1 st == P_END && done);
  c_fail: cover property (@(posedge ref_clk) disable iff (!rst_n)
    st == P_RECHK ##1 st == P_RST);
  c_manual_reset: cover property (@(posedge ref_clk) disable iff (!rst_n)
    cyc_idle && reset_cmd);
endmodule

// *** design/flash_poll_pkg.sv ***
package flash_poll_pkg;
  // register byte offsets
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] STATUS_OFF = 8'h04;
  localparam logic [7:0] ADDR_OFF = 8'h08;
  localparam logic [7:0] DATA_OFF = 8'h0C;
  localparam logic [7:0] LAST_OFF = 8'h10;
  // control fields
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_RESET_BIT = 1;
  localparam int CTRL_ERASE_BIT = 2;
  localparam int CTRL_ESP_BIT = 3;
  // status fields
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_DONE_BIT = 1;
  localparam int ST_FAIL_BIT = 2;
  localparam int ST_RDY_BIT = 3;
  localparam int ST_WIN_BIT = 4;
  localparam int ST_ESTG_BIT = 5;
  // status bit positions in the polled byte
  localparam int POLL_BIT = 7;
  localparam int BTOG_BIT = 6;
  localparam int TLIM_BIT = 5;
  localparam int EWIN_BIT = 3;
  localparam int ESTG_BIT = 2;
  // flash reset command
  localparam logic [7:0] RESET_CMD = 8'hF0;
  localparam logic [19:0] ANY_ADDR = 20'h00000;
  // bus cycle timing at 100 MHz
  localparam int CLK_NS = 10;
  localparam int T_RD_NS = 90;
  localparam int T_WR_NS = 50;
  localparam int T_RD_CYC = (T_RD_NS + CLK_NS - 1) / CLK_NS;
  localparam int T_WR_CYC = (T_WR_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0] RD_CNT = 4'(T_RD_CYC);
  localparam logic [3:0] WR_CNT = 4'(T_WR_CYC);
  localparam logic [3:0] GAP_CNT = 4'h2;
endpackage

// *** design/flash_bus_cycle.sv ***
`timescale 1ns/1ps
// one flash read or write bus cycle, strobes paced by cycle counts
module flash_bus_cycle
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // request
  input wire logic req,
  input wire logic is_write,
  input wire logic [19:0] addr,
  input wire logic [7:0] wdata,
  output logic done,
  output logic [7:0] rdata,
  // flash pins
  output logic [19:0] f_addr,
  output logic f_ce_n,
  output logic f_oe_n,
  output logic f_we_n,
  output logic [7:0] f_dq_o,
  output logic f_dq_oe,
  input wire logic [7:0] f_dq_i
);
  typedef enum logic [1:0] {CY_IDLE, CY_ACT, CY_GAP} cy_t;
  cy_t st;
  logic [3:0] cnt;
  logic wr;
  logic [7:0] dq_s1;
  logic [7:0] dq_s2;
  wire cnt_zero = (cnt == 4'h0);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dq_s1 <= 8'h00;
      dq_s2 <= 8'h00;
    end
    else
    begin
      dq_s1 <= f_dq_i;
      dq_s2 <= dq_s1;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st <= CY_IDLE;
      cnt <= 4'h0;
      wr <= 1'b0;
      done <= 1'b0;
      rdata <= 8'h00;
      f_addr <= 20'h00000;
      f_ce_n <= 1'b1;
      f_oe_n <= 1'b1;
      f_we_n <= 1'b1;
      f_dq_o <= 8'h00;
      f_dq_oe <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      case (st)
        CY_IDLE:
        begin
          if (req)
          begin
            st <= CY_ACT;
            wr <= is_write;
            f_addr <= addr;
            f_ce_n <= 1'b0;
            f_oe_n <= is_write;
            f_we_n <= !is_write;
            f_dq_o <= wdata;
            f_dq_oe <= is_write;
            cnt <= is_write ? flash_poll_pkg::WR_CNT
                            : flash_poll_pkg::RD_CNT;
          end
        end
        CY_ACT:
        begin
          if (cnt_zero)
          begin
            // rising strobe ends the cycle; the device flips its toggles here
            if (!wr)
              rdata <= dq_s2;
            f_ce_n <= 1'b1;
            f_oe_n <= 1'b1;
            f_we_n <= 1'b1;
            cnt <= flash_poll_pkg::GAP_CNT;
            st <= CY_GAP;
          end
          else
            cnt <= cnt - 4'h1;
        end
        CY_GAP:
        begin
          f_dq_oe <= 1'b0;
          if (cnt_zero)
          begin
            done <= 1'b1;
            st <= CY_IDLE;
          end
          else
            cnt <= cnt - 4'h1;
        end
        default: st <= CY_IDLE;
      endcase
    end
  end
endmodule

// *** sim/flash_dev_model.sv ***
`timescale 1ns/1ps
// behavioural status side of the flash device
module flash_dev_model
(
  // flash pins
  input wire logic [19:0] f_addr,
  input wire logic f_ce_n,
  input wire logic f_oe_n,
  input wire logic f_we_n,
  input wire logic [7:0] f_dq_o,
  input wire logic f_dq_oe,
  output logic [7:0] f_dq_i,
  output wire logic ready_busy_out
);
  int busy_reads = 0;
  int resets = 0;
  logic tlim = 1'b0;
  logic erase = 1'b0;
  logic [7:0] arr = 8'h00;
  logic [19:0] last_addr = 20'h00000;
  logic tog1 = 1'b0;
  logic tog2 = 1'b0;
  logic [7:0] held = 8'h00;
  logic [7:0] cmd = 8'h00;
  wire busy = busy_reads != 0;
  wire rd = !f_ce_n && !f_oe_n;
  wire [7:0] stat;
  // poll, toggle, limit, 0, window, second toggle, 0, 0
  assign stat = busy ?
    {erase ? 1'b0 : ~arr[7], tog1, tlim, 1'b0,
     erase, erase & tog2, 2'b00}
    : arr;
  // released bus shows the inverse of the last byte
  assign f_dq_i = rd ? stat : held;
  assign ready_busy_out = busy ? 1'b0 : 1'b1;
  always @(posedge rd)
    last_addr = f_addr;
  always @(negedge rd)
  begin
    held = ~stat;
    if (busy)
    begin
      tog1 = ~tog1;
      tog2 = erase ? ~tog2 : tog2;
      if (busy_reads > 0)
        busy_reads = busy_reads - 1;
    end
  end
  always @*
    if (!f_we_n && f_dq_oe)
      cmd = f_dq_o;
  // only the reset command clears a timed-out operation
  always @(posedge f_we_n)
    if (cmd == 8'hF0)
    begin
      busy_reads = 0;
      tlim = 1'b0;
      resets = resets + 1;
      cmd = 8'h00;
    end
endmodule

// *** sim/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] s_awaddr = 8'h00;
  logic s_awvalid = 1'b0;
  logic s_awready;
  logic [31:0] s_wdata = 32'h0;
  logic [3:0] s_wstrb = 4'h0;
  logic s_wvalid = 1'b0;
  logic s_wready;
  logic [1:0] s_bresp;
  logic s_bvalid;
  logic s_bready = 1'b0;
  logic [7:0] s_araddr = 8'h00;
  logic s_arvalid = 1'b0;
  logic s_arready;
  logic [31:0] s_rdata;
  logic [1:0] s_rresp;
  logic s_rvalid;
  logic s_rready = 1'b0;
  logic [19:0] f_addr;
  logic f_ce_n;
  logic f_oe_n;
  logic f_we_n;
  logic [7:0] f_dq_o;
  logic f_dq_oe;
  logic [7:0] f_dq_i;
  wire ready_busy_out;
  int fails = 0;
  int total_checks = 0;
  logic [31:0] seed = 32'h0000CDC3;

  initial
  begin
    forever #5 ref_clk = ~ref_clk;
  end

  flash_poll_host i_flash_poll_host
  (
    .ref_clk(ref_clk), .resetn(resetn),
    .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready),
    .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid),
    .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid),
    .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
    .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp),
    .s_rvalid(s_rvalid), .s_rready(s_rready), .f_addr(f_addr),
    .f_ce_n(f_ce_n), .f_oe_n(f_oe_n), .f_we_n(f_we_n), .f_dq_o(f_dq_o),
    .f_dq_oe(f_dq_oe), .f_dq_i(f_dq_i), .ready_busy_out(ready_busy_out)
  );

  flash_dev_model i_flash_dev_model
  (
    .f_addr(f_addr), .f_ce_n(f_ce_n), .f_oe_n(f_oe_n), .f_we_n(f_we_n),
    .f_dq_o(f_dq_o), .f_dq_oe(f_dq_oe), .f_dq_i(f_dq_i),
    .ready_busy_out(ready_busy_out)
  );

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // busy, done and fail bits after an operation
  function automatic logic [31:0] exp_st(input logic ok);
    return {29'h0, ~ok, ok, 1'b0};
  endfunction

  task automatic tally_and_finish();
    if (fails == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic hang(input string what);
    fails++;
    $display("ERROR %0t timeout %s", $time, what);
    tally_and_finish();
  endtask

  task automatic chk_reg(input logic [31:0] got, exp, input string what);
    total_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_resp(input logic [1:0] got, exp);
    total_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("ERROR %0t resp got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_cnt(input int got, exp);
    total_checks++;
    if (got != exp)
    begin
      fails++;
      $display("ERROR %0t count got %0d exp %0d", $time, got, exp);
    end
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        output logic [1:0] r);
    int n;
    logic got;
    n = 0;
    got = 1'b0;
    r = 2'h3;
    @(posedge ref_clk);
    s_awaddr <= a;
    s_wdata <= d;
    s_wstrb <= 4'hF;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    while (!got && n < 300)
    begin
      @(posedge ref_clk);
      n++;
      if (s_awvalid && s_awready === 1'b1)
        s_awvalid <= 1'b0;
      if (s_wvalid && s_wready === 1'b1)
        s_wvalid <= 1'b0;
      if (s_bready && s_bvalid === 1'b1)
      begin
        r = s_bresp;
        got = 1'b1;
        s_bready <= 1'b0;
      end
    end
    if (!got)
      hang("write");
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    int n;
    logic got;
    n = 0;
    got = 1'b0;
    d = 32'h0;
    r = 2'h3;
    @(posedge ref_clk);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    while (!got && n < 300)
    begin
      @(posedge ref_clk);
      n++;
      if (s_arvalid && s_arready === 1'b1)
        s_arvalid <= 1'b0;
      if (s_rready && s_rvalid === 1'b1)
      begin
        d = s_rdata;
        r = s_rresp;
        got = 1'b1;
        s_rready <= 1'b0;
      end
    end
    if (!got)
      hang("read");
  endtask

  initial
  begin
    logic [31:0] d;
    logic [31:0] v;
    logic [1:0] r;
    logic [19:0] ad;
    int n;
    int nres;
    repeat (10) @(posedge ref_clk);
    resetn <= 1'b1;
    repeat (4) @(posedge ref_clk);
    axi_rd(flash_poll_pkg::STATUS_OFF, d, r);
    chk_reg(d & 32'h0000000F, 32'h00000008, "status after reset");
    axi_rd(8'h14, d, r);
    chk_resp(r, 2'h2);
    chk_reg(d, 32'h0, "unmapped read");
    axi_wr(8'h20, 32'h1, r);
    chk_resp(r, 2'h2);
    // idle, program, erase, timed-out program
    for (int k = 0; k < 4; k++)
    begin
      d = xs();
      ad = d[19:0];
      axi_wr(flash_poll_pkg::ADDR_OFF, {12'h0, ad}, r);
      chk_resp(r, 2'h0);
      axi_rd(flash_poll_pkg::ADDR_OFF, d, r);
      chk_reg(d & 32'h000FFFFF, {12'h0, ad}, "address");
      v = xs();
      axi_wr(flash_poll_pkg::DATA_OFF, {24'h0, v[7:0]}, r);
      chk_resp(r, 2'h0);
      axi_rd(flash_poll_pkg::DATA_OFF, d, r);
      chk_reg(d, {24'h0, v[7:0]}, "expected data");
      i_flash_dev_model.arr = v[7:0];
      i_flash_dev_model.tlim = (k == 3);
      i_flash_dev_model.erase = (k == 2);
      i_flash_dev_model.busy_reads = k == 0 ? 0 : k == 3 ? -1 :
                                     1 + int'(v[9:8]);
      nres = i_flash_dev_model.resets;
      repeat (3) @(posedge ref_clk);
      axi_wr(flash_poll_pkg::CTRL_OFF, k == 2 ? 32'h5 : 32'h1, r);
      axi_rd(flash_poll_pkg::STATUS_OFF, d, r);
      if (k != 0)
        chk_reg(d & 32'h9, 32'h1, "busy with pin low");
      n = 0;
      while (n < 100 && !(d[0] === 1'b0 && d[2:1] !== 2'b00))
      begin
        axi_rd(flash_poll_pkg::STATUS_OFF, d, r);
        n++;
      end
      if (n >= 100)
        hang("poll");
      chk_reg(d & 32'h7, exp_st(k != 3), "outcome");
      chk_reg({12'h0, i_flash_dev_model.last_addr}, {12'h0, ad},
              "poll address");
      chk_cnt(i_flash_dev_model.resets, nres + (k == 3));
      if (k != 3)
      begin
        axi_rd(flash_poll_pkg::LAST_OFF, d, r);
        chk_reg(d & 32'hFF, {24'h0, v[7:0]}, "array byte");
      end
    end
    // software-ordered reset command
    nres = i_flash_dev_model.resets;
    axi_wr(flash_poll_pkg::CTRL_OFF, 32'h2, r);
    n = 0;
    while (i_flash_dev_model.resets == nres && n < 200)
    begin
      @(posedge ref_clk);
      n++;
    end
    chk_cnt(i_flash_dev_model.resets, nres + 1);
    tally_and_finish();
  end
endmodule
